/* File: hw/ppb_pkg.sv */
// ==========================================================
// primary bus constants
package ppb_pkg;
    localparam int AD_W = 32;
    localparam int CBE_W = 4;
    localparam int FIFO_W = AD_W + CBE_W;
    localparam int FIFO_DEPTH = 16;
    localparam int LEN_W = 5;
    localparam int SYNC_STAGES = 2;
    localparam logic [3:0] CMD_DAC = 4'hD;
    localparam logic [31:0] PARK_AD = 32'h0000_0000;
    localparam logic [3:0] PARK_CBE = 4'h0;
    localparam logic [2:0] DEVSEL_LIMIT = 3'h5;
    localparam logic [4:0] ONE_LEFT = 5'h01;
    localparam logic [5:0] CTL_RST = 6'h3F;
    localparam logic [35:0] BUS_RST = 36'h0_0000_0000;
    localparam int CTL_GNT = 5;
    localparam int CTL_FRAME = 4;
    localparam int CTL_IRDY = 3;
    localparam int CTL_TRDY = 2;
    localparam int CTL_DEVSEL = 1;
    localparam int CTL_PAR = 0;
    localparam int BUS_CBE_LSB = 0;
    localparam int BUS_AD_LSB = 4;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_ADDR2 = 6'h04,
        ST_DATA = 6'h08,
        ST_ABORT = 6'h10,
        ST_TURN = 6'h20
    } ppb_state_type;

    function automatic logic ppb_even_par(input logic [31:0] ad, input logic [3:0] cbe);
        return ^{ad, cbe};
    endfunction
endpackage

/* File: hw/ppb_stream_if.sv */
`timescale 1ns/1ps
// ==========================================================
// valid/ready word stream between internal blocks
interface ppb_stream_if #(parameter int W = 36);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: hw/ppb_sync.sv */
`timescale 1ns/1ps
// ==========================================================
// two-stage pin synchroniser
module ppb_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q <= RST;
            o_q <= RST;
        end else if (i_ce) begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule

/* File: hw/ppb_fifo.sv */
`timescale 1ns/1ps
// ==========================================================
// flop based fifo, depth a power of two
module ppb_fifo #(
    parameter int W = 36,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    ppb_stream_if.snk s_in,
    ppb_stream_if.src s_out
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q, cnt_d;
    logic ready_q, push, pop;

    assign push = s_in.valid & ready_q;
    assign pop = s_out.valid & s_out.ready;
    assign s_in.ready = ready_q;
    assign s_out.valid = (cnt_q != '0);
    assign s_out.data = mem_q[rp_q];
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            mem_q[wp_q] <= s_in.data;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b0;
        end else if (i_ce) begin
            wp_q <= wp_q + AW'(push);
            rp_q <= rp_q + AW'(pop);
            cnt_q <= cnt_d;
            ready_q <= (cnt_d != FULL);
        end
    end
endmodule

/* File: hw/ppb_primary.sv */
`timescale 1ns/1ps
module ppb_primary
    import ppb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_req_valid,
    input wire logic [31:0] i_req_addr,
    input wire logic [31:0] i_req_addr_hi,
    input wire logic i_req_dual,
    input wire logic [3:0] i_req_cmd,
    input wire logic i_req_write,
    input wire logic [3:0] i_req_be,
    input wire logic [4:0] i_req_len,
    output logic o_req_ready,
    input wire logic i_wr_valid,
    input wire logic [31:0] i_wr_data,
    input wire logic [3:0] i_wr_be,
    output logic o_wr_ready,
    output logic [31:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_done,
    output logic o_master_abort,
    output logic o_parity_error,
    input wire logic i_gnt_n,
    input wire logic [31:0] i_ad,
    output logic [31:0] o_ad,
    output logic o_ad_oe,
    input wire logic [3:0] i_cbe,
    output logic [3:0] o_cbe,
    output logic o_cbe_oe,
    input wire logic i_par,
    output logic o_par,
    output logic o_par_oe,
    input wire logic i_frame_n,
    output logic o_frame_n,
    output logic o_frame_oe,
    input wire logic i_irdy_n,
    output logic o_irdy_n,
    output logic o_irdy_oe,
    input wire logic i_trdy_n,
    input wire logic i_devsel_n
);
    // ==========================================================
    // pin sampling
    // every pin is seen two clocks late; the bus logic works on that
    // delayed view, trading latency for clean sampling
    logic [5:0] ctl_s;
    logic [35:0] bus_s;
    logic gnt_n_s, frame_n_s, irdy_n_s, trdy_n_s, devsel_n_s, par_s, bus_idle_s;
    logic [31:0] ad_s;
    logic [3:0] cbe_s;

    ppb_sync #(.W(6), .RST(CTL_RST)) u_ctl_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_d({i_gnt_n, i_frame_n, i_irdy_n, i_trdy_n, i_devsel_n, i_par}),
        .o_q(ctl_s)
    );
    ppb_sync #(.W(36), .RST(BUS_RST)) u_bus_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_d({i_ad, i_cbe}),
        .o_q(bus_s)
    );

    assign gnt_n_s = ctl_s[CTL_GNT];
    assign frame_n_s = ctl_s[CTL_FRAME];
    assign irdy_n_s = ctl_s[CTL_IRDY];
    assign trdy_n_s = ctl_s[CTL_TRDY];
    assign devsel_n_s = ctl_s[CTL_DEVSEL];
    assign par_s = ctl_s[CTL_PAR];
    assign ad_s = bus_s[BUS_AD_LSB +: AD_W];
    assign cbe_s = bus_s[BUS_CBE_LSB +: CBE_W];
    assign bus_idle_s = frame_n_s & irdy_n_s;

    // ==========================================================
    // write data buffer
    ppb_stream_if #(.W(FIFO_W)) wr_in ();
    ppb_stream_if #(.W(FIFO_W)) wr_out ();

    assign wr_in.valid = i_wr_valid;
    assign wr_in.data = {i_wr_data, i_wr_be};
    assign o_wr_ready = wr_in.ready;

    ppb_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .s_in(wr_in),
        .s_out(wr_out)
    );

    // ==========================================================
    // request latch
    ppb_state_type state_q, state_d;
    logic pend_q, ready_q, dual_q, write_q;
    logic [31:0] addr_q, addr_hi_q;
    logic [3:0] cmd_q, be_q;
    logic [4:0] len_q, remain_q, rem_d;
    logic take, start, complete, park, load_wr, irdy_n_d;

    assign take = i_req_valid & ready_q;
    assign start = (state_q == ST_IDLE) & pend_q & !gnt_n_s & bus_idle_s;
    assign o_req_ready = ready_q;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pend_q <= 1'b0;
            ready_q <= 1'b0;
            addr_q <= '0;
            addr_hi_q <= '0;
            dual_q <= 1'b0;
            cmd_q <= '0;
            write_q <= 1'b0;
            be_q <= '0;
            len_q <= '0;
        end else if (i_ce) begin
            if (take) begin
                pend_q <= 1'b1;
                addr_q <= i_req_addr;
                addr_hi_q <= i_req_addr_hi;
                dual_q <= i_req_dual;
                cmd_q <= i_req_cmd;
                write_q <= i_req_write;
                be_q <= i_req_be;
                len_q <= i_req_len;
            end else if (start) begin
                pend_q <= 1'b0;
            end
            ready_q <= (state_q == ST_IDLE) & !pend_q & !take;
        end
    end

    // ==========================================================
    // transaction sequencing
    logic [2:0] dev_cnt_q;
    logic dev_ok_q, abort_hit;

    assign complete = (state_q == ST_DATA) & !o_irdy_n & !trdy_n_s;
    assign rem_d = remain_q - 5'(complete);
    assign abort_hit = !dev_ok_q & devsel_n_s & (dev_cnt_q == DEVSEL_LIMIT)
        & ((state_q == ST_ADDR2) | (state_q == ST_DATA));
    // a new write word is loaded only when the current one has gone
    assign load_wr = (state_d == ST_DATA) & write_q & wr_out.valid & (rem_d != '0)
        & (o_irdy_n | complete);
    assign wr_out.ready = load_wr;
    assign irdy_n_d = write_q ? !(load_wr | (!o_irdy_n & !complete)) : 1'b0;
    assign park = (state_q == ST_IDLE) & !pend_q & !gnt_n_s & bus_idle_s;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_ADDR;
                end
            end
            ST_ADDR: state_d = dual_q ? ST_ADDR2 : ST_DATA;
            ST_ADDR2: state_d = abort_hit ? ST_ABORT : ST_DATA;
            ST_DATA: begin
                if (abort_hit) begin
                    state_d = ST_ABORT;
                end else if (complete && rem_d == '0) begin
                    state_d = ST_TURN;
                end
            end
            ST_ABORT: state_d = ST_TURN;
            ST_TURN: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= ST_IDLE;
            remain_q <= '0;
            dev_cnt_q <= '0;
            dev_ok_q <= 1'b0;
        end else if (i_ce) begin
            state_q <= state_d;
            remain_q <= (state_d == ST_ADDR) ? len_q : rem_d;
            if (state_d == ST_ADDR) begin
                dev_cnt_q <= '0;
                dev_ok_q <= 1'b0;
            end else begin
                if (!devsel_n_s) begin
                    dev_ok_q <= 1'b1;
                end
                if (dev_cnt_q != DEVSEL_LIMIT) begin
                    dev_cnt_q <= dev_cnt_q + 3'h1;
                end
            end
        end
    end

    // ==========================================================
    // address/data and command lines
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ad <= PARK_AD;
            o_ad_oe <= 1'b0;
            o_cbe <= PARK_CBE;
            o_cbe_oe <= 1'b0;
        end else if (i_ce) begin
            case (state_d)
                ST_IDLE: begin
                    o_ad_oe <= park;
                    o_cbe_oe <= park;
                    o_ad <= PARK_AD;
                    o_cbe <= PARK_CBE;
                end
                ST_ADDR: begin
                    o_ad_oe <= 1'b1;
                    o_cbe_oe <= 1'b1;
                    o_ad <= addr_q;
                    o_cbe <= dual_q ? CMD_DAC : cmd_q;
                end
                ST_ADDR2: begin
                    o_ad <= addr_hi_q;
                    o_cbe <= cmd_q;
                end
                ST_DATA: begin
                    o_ad_oe <= write_q;
                    if (!write_q) begin
                        o_cbe <= be_q;
                    end else if (load_wr) begin
                        o_ad <= wr_out.data[BUS_AD_LSB +: AD_W];
                        o_cbe <= wr_out.data[BUS_CBE_LSB +: CBE_W];
                    end
                end
                ST_ABORT: begin
                    o_cbe_oe <= 1'b1;
                end
                ST_TURN: begin
                    o_ad_oe <= 1'b0;
                    o_cbe_oe <= 1'b0;
                end
                default: begin
                    o_ad_oe <= 1'b0;
                    o_cbe_oe <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // framing and initiator ready
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_frame_n <= 1'b1;
            o_frame_oe <= 1'b0;
            o_irdy_n <= 1'b1;
            o_irdy_oe <= 1'b0;
        end else if (i_ce) begin
            case (state_d)
                ST_ADDR: begin
                    o_frame_n <= 1'b0;
                    o_frame_oe <= 1'b1;
                    o_irdy_n <= 1'b1;
                    o_irdy_oe <= 1'b1;
                end
                ST_ADDR2: o_irdy_n <= 1'b1;
                ST_DATA: begin
                    o_irdy_n <= irdy_n_d;
                    o_frame_n <= o_frame_n | (!irdy_n_d & (rem_d == ONE_LEFT));
                end
                ST_ABORT: begin
                    o_frame_n <= 1'b1;
                    o_irdy_n <= 1'b0;
                end
                ST_TURN: begin
                    o_frame_n <= 1'b1;
                    o_irdy_n <= 1'b1;
                end
                default: begin
                    o_frame_oe <= 1'b0;
                    o_irdy_oe <= 1'b0;
                    o_frame_n <= 1'b1;
                    o_irdy_n <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // parity generation and checking
    logic chk_q, exp_q, fr_prev_q;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_par <= 1'b0;
            o_par_oe <= 1'b0;
            chk_q <= 1'b0;
            exp_q <= 1'b0;
            fr_prev_q <= 1'b1;
            o_parity_error <= 1'b0;
        end else if (i_ce) begin
            o_par <= ppb_even_par(o_ad, o_cbe);
            o_par_oe <= o_ad_oe;
            // check read data and foreign addresses
            fr_prev_q <= frame_n_s;
            chk_q <= (complete & !write_q) | ((state_q == ST_IDLE) & fr_prev_q & !frame_n_s & !o_frame_oe);
            exp_q <= ppb_even_par(ad_s, cbe_s);
            o_parity_error <= chk_q & (par_s != exp_q);
        end
    end

    // ==========================================================
    // user side results
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_data <= '0;
            o_rd_valid <= 1'b0;
            o_done <= 1'b0;
            o_master_abort <= 1'b0;
        end else if (i_ce) begin
            o_rd_valid <= complete & !write_q;
            if (complete && !write_q) begin
                o_rd_data <= ad_s;
            end
            o_done <= (state_d == ST_TURN);
            o_master_abort <= (state_d == ST_ABORT);
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n || !i_ce);

    sequence s_release;
        o_frame_oe && o_frame_n ##1 !o_frame_oe;
    endsequence

    property p_park;
        park && state_d == ST_IDLE |=> o_ad_oe && o_cbe_oe && o_ad == PARK_AD;
    endproperty
    a_park: assert property (p_park) else $error("idle granted bus not parked");

    property upstream_parity_on;
        $rose(o_ad_oe) |=> $rose(o_par_oe);
    endproperty
    a_par_on: assert property (upstream_parity_on) else $error("parity drive not one clock late");

    property upstream_parity_off;
        $fell(o_ad_oe) |=> $fell(o_par_oe);
    endproperty
    a_par_off: assert property (upstream_parity_off) else $error("parity release not one clock late");

    property upstream_parity_val;
        o_ad_oe |=> o_par == ^{$past(o_ad), $past(o_cbe)};
    endproperty
    a_par_val: assert property (upstream_parity_val) else $error("parity value wrong");

    property p_dac;
        state_q == ST_ADDR && dual_q |=> o_cbe == cmd_q && state_q == ST_ADDR2;
    endproperty
    a_dac: assert property (p_dac) else $error("second address phase command wrong");

    property p_irdy_hold;
        state_q == ST_DATA && !o_irdy_n && trdy_n_s && !abort_hit |=> !o_irdy_n;
    endproperty
    a_irdy_hold: assert property (p_irdy_hold) else $error("irdy dropped before completion");

    property p_frame_end;
        state_q == ST_TURN |-> s_release;
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("frame not released after one high clock");

    property p_abort;
        abort_hit |=> state_q == ST_ABORT ##1 state_q == ST_TURN ##1 state_q == ST_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("master abort sequence wrong");

    property p_last;
        state_q == ST_DATA && o_frame_n && !o_irdy_n |-> remain_q == ONE_LEFT;
    endproperty
    a_last: assert property (p_last) else $error("frame deasserted before final phase");
endmodule

/* File: tb/ppb_target_model.sv */
`timescale 1ns/1ps
// ==========================================================
// target agent on the upstream bus, fast decode, no wait states
module ppb_target_model
    import ppb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_respond,
    input wire logic i_bad_par,
    input wire logic [31:0] i_rd_word,
    input wire logic [31:0] i_ad,
    input wire logic [3:0] i_cbe,
    input wire logic i_frame_n,
    input wire logic i_irdy_n,
    output logic o_trdy_n,
    output logic o_devsel_n,
    output logic [31:0] o_ad,
    output logic o_ad_oe,
    output logic o_par,
    output logic o_par_oe
);
    logic busy, wr, frame_q;
    logic [1:0] trdy_h;
    logic [3:0] cnt, cmd1, cmd2;
    logic [31:0] addr_lo, addr_hi;
    logic [35:0] words[$];
    int n_done, n_last;

    // completions are counted with the initiator's two-clock view of target ready
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy <= 1'b0;
            frame_q <= 1'b1;
            trdy_h <= 2'h3;
            cnt <= 4'h0;
            o_trdy_n <= 1'b1;
            o_devsel_n <= 1'b1;
            o_ad <= 32'h0000_0000;
            o_ad_oe <= 1'b0;
            o_par <= 1'b0;
            o_par_oe <= 1'b0;
        end else begin
            frame_q <= i_frame_n;
            trdy_h <= {trdy_h[0], o_trdy_n};
            // even parity of own data, one clock behind
            o_par <= ^{o_ad, i_cbe} ^ i_bad_par;
            o_par_oe <= o_ad_oe;
            if (!busy && frame_q && !i_frame_n) begin
                // frame fall marks the address phase
                busy <= 1'b1;
                cnt <= 4'h1;
                addr_lo <= i_ad;
                cmd1 <= i_cbe;
                cmd2 <= i_cbe;
                wr <= i_cbe[0];
                n_done <= 0;
                n_last <= 0;
                words.delete();
            end else if (busy) begin
                if (cnt != 4'hF) begin
                    cnt <= cnt + 4'h1;
                end
                if (cnt == 4'h1 && cmd1 == CMD_DAC) begin
                    addr_hi <= i_ad;
                    cmd2 <= i_cbe;
                    wr <= i_cbe[0];
                end
                if (cnt == 4'h1 && i_respond) begin
                    // read data and target ready held over the burst
                    o_devsel_n <= 1'b0;
                    o_trdy_n <= 1'b0;
                    o_ad <= i_rd_word;
                    o_ad_oe <= (cmd1 == CMD_DAC) ? !i_cbe[0] : !wr;
                end
                if (!i_irdy_n && !trdy_h[1]) begin
                    // one word with its byte enables per phase
                    words.push_back({i_cbe, i_ad});
                    n_done <= n_done + 1;
                    n_last <= n_last + int'(i_frame_n);
                end
                if (i_frame_n && i_irdy_n) begin
                    // idle bus: deassert and let go
                    busy <= 1'b0;
                    o_devsel_n <= 1'b1;
                    o_trdy_n <= 1'b1;
                    o_ad_oe <= 1'b0;
                end
            end
        end
    end
endmodule

/* File: tb/ppb_primary_bench.sv */
`timescale 1ns/1ps
// ==========================================================
// upstream bus bench
module ppb_primary_bench
    import ppb_pkg::*;
;
    logic i_clk, i_arst_n, i_req_valid, i_req_dual, i_req_write, i_wr_valid, i_gnt_n;
    logic [31:0] i_req_addr, i_req_addr_hi, i_wr_data, rd_word, ad_w, t_ad, o_rd_data, o_ad;
    logic [31:0] ad_hold = 32'h0000_0000;
    logic [3:0] i_req_cmd, i_req_be, i_wr_be, cbe_w, o_cbe;
    logic [3:0] cbe_hold = 4'h0;
    logic [4:0] i_req_len;
    logic [35:0] prev_bus;
    logic par_hold = 1'b0;
    logic respond, bad_par, par_w, frame_w, irdy_w, prev_ad_oe, prev_fr_n, prev_fr_oe, prev_ir_n, prev_ir_oe;
    logic t_trdy_n, t_devsel_n, t_ad_oe, t_par, t_par_oe;
    logic o_req_ready, o_wr_ready, o_rd_valid, o_done, o_master_abort, o_parity_error;
    logic o_ad_oe, o_cbe_oe, o_par, o_par_oe, o_frame_n, o_frame_oe, o_irdy_n, o_irdy_oe;
    int num_errors, num_checks, rd_cnt, ab_cnt, pe_cnt;

    // undriven lines without pull-up flip every cycle so a stale value never passes
    assign ad_w = o_ad_oe ? o_ad : (t_ad_oe ? t_ad : ~ad_hold);
    assign cbe_w = o_cbe_oe ? o_cbe : ~cbe_hold;
    assign par_w = o_par_oe ? o_par : (t_par_oe ? t_par : ~par_hold);
    assign frame_w = o_frame_oe ? o_frame_n : 1'b1;
    assign irdy_w = o_irdy_oe ? o_irdy_n : 1'b1;

    ppb_primary uut (.i_clk, .i_arst_n, .i_ce(1'b1), .i_req_valid, .i_req_addr, .i_req_addr_hi, .i_req_dual,
        .i_req_cmd, .i_req_write, .i_req_be, .i_req_len, .o_req_ready, .i_wr_valid, .i_wr_data, .i_wr_be,
        .o_wr_ready, .o_rd_data, .o_rd_valid, .o_done, .o_master_abort, .o_parity_error, .i_gnt_n,
        .i_ad(ad_w), .o_ad, .o_ad_oe, .i_cbe(cbe_w), .o_cbe, .o_cbe_oe, .i_par(par_w), .o_par, .o_par_oe,
        .i_frame_n(frame_w), .o_frame_n, .o_frame_oe, .i_irdy_n(irdy_w), .o_irdy_n, .o_irdy_oe,
        .i_trdy_n(t_trdy_n), .i_devsel_n(t_devsel_n));

    ppb_target_model model (.i_clk, .i_arst_n, .i_respond(respond), .i_bad_par(bad_par), .i_rd_word(rd_word),
        .i_ad(ad_w), .i_cbe(cbe_w), .i_frame_n(frame_w), .i_irdy_n(irdy_w), .o_trdy_n(t_trdy_n),
        .o_devsel_n(t_devsel_n), .o_ad(t_ad), .o_ad_oe(t_ad_oe), .o_par(t_par), .o_par_oe(t_par_oe));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // ==========================================================
    // wire monitor
    // judged at the falling edge, half a cycle after the outputs have settled
    always @(negedge i_clk) begin
        ad_hold <= ad_w;
        cbe_hold <= cbe_w;
        par_hold <= par_w;
        prev_bus <= {o_ad, o_cbe};
        prev_ad_oe <= o_ad_oe;
        prev_fr_n <= o_frame_n;
        prev_fr_oe <= o_frame_oe;
        prev_ir_n <= o_irdy_n;
        prev_ir_oe <= o_irdy_oe;
        if (i_arst_n === 1'b1) begin
            check("par_oe", o_par_oe, prev_ad_oe);
            if (o_par_oe === 1'b1) check("par", o_par, ^prev_bus);
            if (prev_fr_oe === 1'b1 && o_frame_oe === 1'b0) check("frame_release", prev_fr_n, 1'b1);
            if (prev_ir_oe === 1'b1 && o_irdy_oe === 1'b0) check("irdy_release", prev_ir_n, 1'b1);
        end
    end

    // ==========================================================
    // transaction tasks
    task automatic wait_done();
        int k;
        int left;
        left = -1;
        rd_cnt = 0;
        ab_cnt = 0;
        pe_cnt = 0;
        for (k = 0; k < 300 && left != 0; k++) begin
            @(negedge i_clk);
            if (o_rd_valid === 1'b1) begin
                rd_cnt++;
                check("rd_data", o_rd_data, rd_word);
            end
            if (o_master_abort === 1'b1) ab_cnt++;
            if (o_parity_error === 1'b1) pe_cnt++;
            if (o_done === 1'b1 && left < 0) left = 4;
            else if (left > 0) left--;
        end
        check("done", left == 0, 1'b1);
    endtask

    task automatic request(input logic [31:0] addr, input logic dual, input logic [3:0] cmd, input logic [4:0] len);
        int k;
        i_req_addr = addr;
        i_req_addr_hi = 32'h0000_0001;
        i_req_dual = dual;
        i_req_cmd = cmd;
        i_req_write = cmd[0];
        i_req_be = 4'h3;
        i_req_len = len;
        i_req_valid = 1'b1;
        for (k = 0; k < 50 && o_req_ready !== 1'b1; k++) @(negedge i_clk);
        check("req_ready", o_req_ready, 1'b1);
        @(negedge i_clk);
        check("req_taken", o_req_ready, 1'b0);
        i_req_valid = 1'b0;
        wait_done();
    endtask

    task automatic t_park();
        cyc(6);
        check("idle_ad_oe", o_ad_oe, 1'b0);
        check("idle_sts_oe", {o_frame_oe, o_irdy_oe}, 2'b00);
        i_gnt_n = 1'b0;
        cyc(6);
        check("park_ad", {o_ad_oe, o_ad}, {1'b1, PARK_AD});
        check("park_cbe", {o_cbe_oe, o_cbe}, {1'b1, PARK_CBE});
        check("park_par", {o_par_oe, o_par}, {1'b1, ^{PARK_AD, PARK_CBE}});
    endtask

    task automatic t_write();
        int i;
        for (i = 0; i < 16; i++) begin
            i_wr_valid = 1'b1;
            i_wr_data = 32'hC0DE_0000 + 32'(i * 257);
            i_wr_be = 4'(i);
            @(negedge i_clk);
            i_wr_valid = 1'b0;
            @(negedge i_clk);
        end
        check("full", o_wr_ready, 1'b0);
        // refused push while full must not reach the bus
        i_wr_valid = 1'b1;
        i_wr_data = 32'hDEAD_0000;
        cyc(2);
        i_wr_valid = 1'b0;
        request(32'h0000_1000, 1'b0, 4'h7, 5'h10);
        check("wr_addr", model.addr_lo, 32'h0000_1000);
        check("wr_cmd", model.cmd1, 4'h7);
        check("wr_phases", model.n_done, 16);
        check("wr_last", model.n_last, 1);
        check("drained", o_wr_ready, 1'b1);
        check("wr_perr", pe_cnt, 0);
        check("wr_abort", ab_cnt, 0);
        for (i = 0; i < 16; i++) check("wr_word", model.words[i], {4'(i), 32'hC0DE_0000 + 32'(i * 257)});
    endtask

    task automatic t_read(input logic dual, input logic bad, input logic [4:0] len);
        int i;
        rd_word = dual ? 32'h5A5A_C3C3 : 32'h0F0F_1234;
        bad_par = bad;
        request(32'h0000_2000, dual, 4'h6, len);
        check("rd_cmd1", model.cmd1, dual ? CMD_DAC : 4'h6);
        check("rd_cmd2", model.cmd2, 4'h6);
        if (dual) check("rd_hi", model.addr_hi, 32'h0000_0001);
        check("rd_count", rd_cnt, int'(len));
        check("rd_last", model.n_last, 1);
        check("rd_perr", pe_cnt, int'(bad));
        check("rd_abort", ab_cnt, 0);
        for (i = 0; i < int'(len); i++) check("rd_be", model.words[i][35:32], 4'h3);
        bad_par = 1'b0;
    endtask

    task automatic t_abort();
        respond = 1'b0;
        request(32'h0000_3000, 1'b0, 4'h6, 5'h02);
        check("abort", ab_cnt, 1);
        check("abort_rd", rd_cnt, 0);
        respond = 1'b1;
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // each transaction takes a few tens of cycles; 4000 cycles is ample
    initial begin
        #(25.0 * 4000);
        num_errors++;
        close_out();
    end

    initial begin
        {i_req_valid, i_req_dual, i_req_write, i_wr_valid, bad_par} = 5'h00;
        {i_req_addr, i_req_addr_hi, i_wr_data, rd_word} = '0;
        {i_req_cmd, i_req_be, i_wr_be, i_req_len} = '0;
        i_gnt_n = 1'b1;
        respond = 1'b1;
        i_arst_n = 1'b0;
        cyc(6);
        i_arst_n = 1'b1;
        t_park();
        t_write();
        t_read(1'b1, 1'b0, 5'h04);
        t_read(1'b0, 1'b1, 5'h01);
        t_abort();
        t_read(1'b0, 1'b0, 5'h10);
        close_out();
    end
endmodule
